// >>> common/watch_map.svh
/*
  holds: coprocessor register numbers, selects, field positions and reset values
  of the watchpoint registers.
  assumes: included by bare name from the watchpoint design file.
*/
`ifndef WATCH_MAP_SVH
`define WATCH_MAP_SVH

// ==========================================================================
// register numbers and selects
`define REG_NUM_RESERVED_LOAD 5'h11
`define REG_NUM_WATCH_ADDR    5'h12
`define REG_NUM_WATCH_QUAL    5'h13
`define SEL_RESERVED_LOAD     3'h0
`define WATCH_PAIRS_MAX       4

// ==========================================================================
// watch address register fields
`define WA_ADDR_HI   31
`define WA_ADDR_LO   3
`define WA_FETCH_BIT 2
`define WA_LOAD_BIT  1
`define WA_STORE_BIT 0

// ==========================================================================
// qualifier register fields
`define WQ_MORE_BIT   31
`define WQ_GLOBAL_BIT 30
`define WQ_TAG_HI     23
`define WQ_TAG_LO     16
`define WQ_MASK_HI    11
`define WQ_MASK_LO    3
`define WQ_FETCH_BIT  2
`define WQ_LOAD_BIT   1
`define WQ_STORE_BIT  0

// ==========================================================================
// reserved-load address field
`define RL_ADDR_HI 27

// ==========================================================================
// reset values
`define WA_RESET 32'h0000_0000
`define WQ_RESET 32'h0000_0000
`define RL_RESET 28'h000_0000

`endif

// >>> common/watch_pkg.sv
/*
  holds: types shared by the watchpoint block.
  assumes: compiled before the design file.
*/
package watch_pkg;

  typedef logic [2:0] hit_vec_t;

  typedef struct packed {
    logic [28:0] base;
    hit_vec_t    enable;
  } watch_addr_s;

  typedef struct packed {
    logic       global_match;
    logic [7:0] space_tag;
    logic [8:0] mask;
    hit_vec_t   status;
  } watch_qual_s;

endpackage

// >>> src/watchpoint_match_unit.sv
/*
  holds: watchpoint match unit with up to four watch pairs and the
  reserved-load address capture register.
  assumes: coprocessor moves, pipeline references and status bits arrive
  synchronous to core_clk; exception logic consumes watch_exc and
  watch_pending each cycle.
*/
`timescale 1ns/100ps
`include "watch_map.svh"

// What this block does
// RULE1: latch latest reserved-load physical address bits 27:0
// RULE2: reserved-load address never affects matching
// RULE3: reserved-load address bits 31:28 read zero
// RULE4: enabled pair match raises watch exception
// RULE5: defer exception while exception or error level
// RULE6: address bits 31:3, enables bits 2:0
// RULE7: enable bit 2 arms fetch matches
// RULE8: enable bit 1 arms load matches
// RULE9: enable bit 0 arms store matches
// RULE10: global bit 30 ignores space tag
// RULE11: otherwise tag 23:16 must equal current tag
// RULE12: mask bits 11:3 exclude address bits
// RULE13: bit 31 flags further pairs exist
// RULE14: fetch match sets sticky bit 2, write-one clears
// RULE15: load match sets sticky bit 1, write-one clears
// RULE16: store match sets sticky bit 0, write-one clears
// RULE17: pairs at selects 0-3 of registers 18, 19
// RULE18: qualifier bits 29:24, 15:12 read zero
// RULE19: match needs type, masked address, tag; status same cycle
module watchpoint_match_unit #(
  parameter int PAIRS = 4
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // coprocessor register access
  input  wire logic        cop_wr,
  input  wire logic [4:0]  cop_reg,
  input  wire logic [2:0]  cop_sel,
  input  wire logic [31:0] cop_wdata,
  output logic      [31:0] cop_rdata,
  // pipeline references
  input  wire logic        fetch_valid,
  input  wire logic [31:0] fetch_virt_match_field,
  input  wire logic        load_valid,
  input  wire logic        store_valid,
  input  wire logic [31:0] data_virt_match_field,
  input  wire logic        reserved_load_valid,
  input  wire logic [31:0] reserved_load_paddr,
  // processor state
  input  wire logic [7:0]  space_tag,
  input  wire logic        exception_level,
  input  wire logic        error_level,
  // exception logic
  output logic             watch_exc,
  output logic             watch_pending
);

  // ========================================================================
  // state
  typedef struct packed {
    watch_pkg::watch_addr_s [PAIRS-1:0] addr;
    watch_pkg::watch_qual_s [PAIRS-1:0] qual;
    logic [`RL_ADDR_HI:0]               rl_addr;
    logic                               pending;
    logic                               exc;
    logic [31:0]                        rdata;
  } state_s;

  state_s st;
  state_s next_st;

  // ========================================================================
  // register decode
  // both the write and the read path go through this, so a select that
  // has no pair behind it is ignored by writes and reads back as zero
  function automatic logic slot_is(input logic [4:0] num,
                                   input logic [2:0] sel,
                                   input logic [4:0] want_num,
                                   input logic [2:0] want_sel);
    slot_is = (num == want_num) && (sel == want_sel);
  endfunction

  // ========================================================================
  // watch address packing
  function automatic watch_pkg::watch_addr_s unpack_addr(input logic [31:0] word);
    watch_pkg::watch_addr_s wa;
    wa.base   = word[`WA_ADDR_HI:`WA_ADDR_LO];                  // [RULE6]
    wa.enable = word[`WA_FETCH_BIT:`WA_STORE_BIT];
    unpack_addr = wa;
  endfunction

  function automatic logic [31:0] pack_addr(input watch_pkg::watch_addr_s wa);
    logic [31:0] word;
    word = 32'h0000_0000;
    word[`WA_ADDR_HI:`WA_ADDR_LO] = wa.base;
    word[`WA_FETCH_BIT:`WA_STORE_BIT] = wa.enable;
    pack_addr = word;
  endfunction

  // ========================================================================
  // qualifier packing
  // the further-pairs bit has no storage: it comes from the pair's position
  function automatic logic [31:0] qual_word(input watch_pkg::watch_qual_s wq,
                                            input logic more);
    qual_word = 32'h0000_0000;
    qual_word[`WQ_MORE_BIT] = more;                          // [RULE13]
    qual_word[`WQ_GLOBAL_BIT] = wq.global_match;
    qual_word[`WQ_TAG_HI:`WQ_TAG_LO] = wq.space_tag;
    qual_word[`WQ_MASK_HI:`WQ_MASK_LO] = wq.mask;
    qual_word[`WQ_FETCH_BIT:0] = wq.status;                  // [RULE18]
  endfunction

  // status bits are write-one-to-clear; the other fields simply load
  function automatic watch_pkg::watch_qual_s write_qual(
    input watch_pkg::watch_qual_s old,
    input logic [31:0]            word
  );
    watch_pkg::watch_qual_s wq;
    wq.global_match = word[`WQ_GLOBAL_BIT];
    wq.space_tag    = word[`WQ_TAG_HI:`WQ_TAG_LO];
    wq.mask         = word[`WQ_MASK_HI:`WQ_MASK_LO];
    wq.status       = old.status & ~word[`WQ_FETCH_BIT:`WQ_STORE_BIT];
    write_qual = wq;
  endfunction

  // ========================================================================
  // matching
  // masked double-word compare; the reserved-load register plays no part
  function automatic logic addr_hit(input watch_pkg::watch_addr_s wa,
                                    input watch_pkg::watch_qual_s wq,
                                    input logic [31:0] va,
                                    input logic [7:0] tag);
    logic [28:0] diff;
    diff = (va[31:3] ^ wa.base) & ~{20'h0_0000, wq.mask};  // [RULE12] [RULE2]
    addr_hit = (diff == 29'h0000_0000) &&
               (wq.global_match || (wq.space_tag == tag));  // [RULE10] [RULE11]
  endfunction

  // one bit per reference type, each gated by its own enable
  function automatic watch_pkg::hit_vec_t type_hits(
    input watch_pkg::watch_addr_s wa,
    input watch_pkg::watch_qual_s wq,
    input logic [7:0]             tag,
    input logic                   fetch,
    input logic [31:0]            fetch_va,
    input logic                   load,
    input logic                   store,
    input logic [31:0]            data_va
  );
    watch_pkg::hit_vec_t h;
    h[`WA_FETCH_BIT] = fetch && wa.enable[`WA_FETCH_BIT] &&
                       addr_hit(wa, wq, fetch_va, tag);          // [RULE7]
    h[`WA_LOAD_BIT]  = load && wa.enable[`WA_LOAD_BIT] &&
                       addr_hit(wa, wq, data_va, tag);           // [RULE8]
    h[`WA_STORE_BIT] = store && wa.enable[`WA_STORE_BIT] &&
                       addr_hit(wa, wq, data_va, tag);           // [RULE9]
    type_hits = h;
  endfunction

  // ========================================================================
  // exception path
  // returns {exception, pending}; any number of deferred hits collapse into
  // the one pending flag, so a release gives a single exception pulse
  function automatic logic [1:0] exc_step(input logic hit,
                                          input logic pend,
                                          input logic held);
    logic [1:0] r;
    if (held) begin
      r = {1'b0, pend | hit};                                    // [RULE5]
    end else begin
      r = {hit | pend, 1'b0};                                    // [RULE4]
    end
    exc_step = r;
  endfunction

  // ========================================================================
  // read path
  // the reserved-load word carries zeros above its 28-bit address
  function automatic logic [31:0] reserved_word(input logic [`RL_ADDR_HI:0] rl);
    reserved_word = {4'h0, rl};                                  // [RULE3]
  endfunction

  function automatic logic [31:0] read_word(input state_s     s,
                                            input logic [4:0] num,
                                            input logic [2:0] sel);
    logic [31:0] word;
    word = 32'h0000_0000;
    if (slot_is(num, sel, `REG_NUM_RESERVED_LOAD, `SEL_RESERVED_LOAD)) begin
      word = reserved_word(s.rl_addr);
    end else begin
      for (int p = 0; p < PAIRS; p++) begin
        if (slot_is(num, sel, `REG_NUM_WATCH_ADDR, 3'(p))) begin
          word = pack_addr(s.addr[p]);
        end else if (slot_is(num, sel, `REG_NUM_WATCH_QUAL, 3'(p))) begin
          word = qual_word(s.qual[p], (p < PAIRS - 1));
        end
      end
    end
    read_word = word;
  endfunction

  // ========================================================================
  // next state
  logic [PAIRS-1:0] pair_fire;

  always_comb begin
    logic                any_hit;
    logic [1:0]          exc_next;
    watch_pkg::hit_vec_t hits;
    any_hit = 1'b0;
    exc_next = 2'h0;
    hits = 3'h0;
    next_st = st;
    pair_fire = '0;

    for (int p = 0; p < PAIRS; p++) begin
      hits = type_hits(st.addr[p], st.qual[p], space_tag, fetch_valid, fetch_virt_match_field,
                       load_valid, store_valid, data_virt_match_field);
      pair_fire[p] = |hits;                                    // [RULE19]
      any_hit = any_hit | pair_fire[p];

      if (cop_wr) begin
        if (slot_is(cop_reg, cop_sel, `REG_NUM_WATCH_ADDR, 3'(p))) begin  // [RULE17]
          next_st.addr[p] = unpack_addr(cop_wdata);
        end else if (slot_is(cop_reg, cop_sel, `REG_NUM_WATCH_QUAL, 3'(p))) begin
          next_st.qual[p] = write_qual(st.qual[p], cop_wdata);
        end
      end
      // a hit in the clearing cycle still lands, so no match is ever lost
      next_st.qual[p].status = next_st.qual[p].status | hits;  // [RULE14] [RULE15] [RULE16]
    end

    // exception only outside exception and error levels, else held pending
    exc_next = exc_step(any_hit, st.pending, exception_level || error_level);
    next_st.exc = exc_next[1];
    next_st.pending = exc_next[0];

    // capture is the only thing that touches the reserved-load address
    if (reserved_load_valid) begin
      next_st.rl_addr = reserved_load_paddr[`RL_ADDR_HI:0];    // [RULE1]
    end

    // registered read data, one cycle behind the register number
    next_st.rdata = read_word(st, cop_reg, cop_sel);
  end

  // ========================================================================
  // registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int p = 0; p < PAIRS; p++) begin
        st.addr[p] <= `WA_RESET;
        st.qual[p] <= '0;
      end
      st.rl_addr <= `RL_RESET;
      st.pending <= 1'b0;
      st.exc <= 1'b0;
      st.rdata <= 32'h0000_0000;
    end else begin
      st <= next_st;
    end
  end

  assign cop_rdata = st.rdata;
  assign watch_exc = st.exc;
  assign watch_pending = st.pending;

endmodule

// >>> sim/watchpoint_match_unit_asserts.sv
/* checker for the watchpoint unit.
   sees only the unit's ports; bound at the foot of this file */
`timescale 1ns/100ps
module watchpoint_match_unit_asserts #(parameter int PAIRS = 4) (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        cop_wr,
  input wire logic [4:0]  cop_reg,
  input wire logic [2:0]  cop_sel,
  input wire logic [31:0] cop_wdata,
  input wire logic [31:0] cop_rdata,
  input wire logic        fetch_valid,
  input wire logic [31:0] fetch_virt_match_field,
  input wire logic        load_valid,
  input wire logic        store_valid,
  input wire logic [31:0] data_virt_match_field,
  input wire logic        reserved_load_valid,
  input wire logic [31:0] reserved_load_paddr,
  input wire logic [7:0]  space_tag,
  input wire logic        exception_level,
  input wire logic        error_level,
  input wire logic        watch_exc,
  input wire logic        watch_pending
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire lvl = exception_level | error_level;
  sequence rl_cap;
    reserved_load_valid ##1 (cop_reg == 5'h11 && cop_sel == 3'h0 && !reserved_load_valid);
  endsequence
  sequence wa_wr;
    cop_wr && cop_reg == 5'h12 && cop_sel == 3'h0 ##1 !cop_wr && cop_reg == 5'h12 && cop_sel == 3'h0;
  endsequence
  rl_capture_a: assert property (rl_cap |=> cop_rdata[27:0] == $past(reserved_load_paddr[27:0], 2))
    else $error("reserved-load address not captured");
  rl_top_a: assert property (cop_reg == 5'h11 |=> cop_rdata[31:28] == 4'h0)
    else $error("reserved-load top bits not zero");
  wa_store_a: assert property (wa_wr |=> cop_rdata == $past(cop_wdata, 2))
    else $error("watch address readback wrong");
  qual_zero_a: assert property (cop_reg == 5'h13 |=> cop_rdata[29:24] == 6'h0 && cop_rdata[15:12] == 4'h0)
    else $error("qualifier unimplemented bits set");
  more_bit_a: assert property (cop_reg == 5'h13 && cop_sel < PAIRS |=> cop_rdata[31] == ($past(cop_sel) < PAIRS - 1))
    else $error("further-pairs bit wrong");
  unmapped_read_a: assert property (cop_reg == 5'h14 |=> cop_rdata == 32'h0)
    else $error("unmapped read not zero");
  level_defer_a: assert property (lvl |=> !watch_exc)
    else $error("watch exception while level set");
  pend_hold_a: assert property (watch_pending && lvl |=> watch_pending)
    else $error("pending dropped early");
  pend_release_a: assert property (watch_pending && !lvl |=> watch_exc && !watch_pending)
    else $error("pending not released");
  exc_cause_a: assert property (!(fetch_valid | load_valid | store_valid | watch_pending) |=> !watch_exc)
    else $error("watch exception without cause");
endmodule
bind watchpoint_match_unit watchpoint_match_unit_asserts #(.PAIRS(PAIRS)) chk (.*);

// >>> sim/pipe_model.sv
/* pipeline side: issues references and holds processor state.
   assumes the bench calls its tasks; drives on falling edges */
`timescale 1ns/100ps
module pipe_model (
  input  wire logic   core_clk,
  output logic        fetch_valid,
  output logic [31:0] fetch_virt_match_field,
  output logic        load_valid,
  output logic        store_valid,
  output logic [31:0] data_virt_match_field,
  output logic        reserved_load_valid,
  output logic [31:0] reserved_load_paddr,
  output logic [7:0]  space_tag,
  output logic        exception_level,
  output logic        error_level
);
  initial begin
    {fetch_valid, load_valid, store_valid, reserved_load_valid} = 4'h0;
    {fetch_virt_match_field, data_virt_match_field, reserved_load_paddr, space_tag} = '0;
    {exception_level, error_level} = 2'h0;
  end
  // k: fetch, load, store, reserved load; released addresses are inverted
  task automatic issue(input logic [3:0] k, input logic [31:0] a, input logic [7:0] t);
    @(negedge core_clk);
    {fetch_valid, load_valid, store_valid, reserved_load_valid} = k;
    {fetch_virt_match_field, data_virt_match_field, reserved_load_paddr} = {a, a, a};
    space_tag = t;
    @(negedge core_clk);
    {fetch_valid, load_valid, store_valid, reserved_load_valid} = 4'h0;
    {fetch_virt_match_field, data_virt_match_field, reserved_load_paddr} = ~{a, a, a};
  endtask
  task automatic levels(input logic e, input logic r);
    @(negedge core_clk);
    exception_level = e;
    error_level = r;
  endtask
endmodule

// >>> sim/watchpoint_match_unit_tb.sv
/* self-checking bench for the watchpoint unit.
   assumes pipe_model and the bound checker are compiled with it */
`timescale 1ns/100ps
module watchpoint_match_unit_tb;
  logic core_clk, rst_n, cop_wr, seen;
  logic [4:0] cop_reg;
  logic [2:0] cop_sel;
  logic [31:0] cop_wdata, cop_rdata, fetch_virt_match_field, data_virt_match_field, reserved_load_paddr;
  logic fetch_valid, load_valid, store_valid, reserved_load_valid;
  logic [7:0] space_tag;
  logic exception_level, error_level, watch_exc, watch_pending;
  int miscompares = 0;
  int samples_checked = 0;
  watchpoint_match_unit #(.PAIRS(4)) uut (.*);
  pipe_model m (.*);
  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [4:0] r, input logic [2:0] s, input logic [31:0] d);
    @(negedge core_clk);
    {cop_wr, cop_reg, cop_sel, cop_wdata} = {1'b1, r, s, d};
    @(negedge core_clk);
    cop_wr = 0;
  endtask
  // read data is registered, so it is judged one cycle after the address
  task automatic rd(input logic [4:0] r, input logic [2:0] s, input logic [31:0] e);
    @(negedge core_clk);
    {cop_reg, cop_sel} = {r, s};
    @(negedge core_clk);
    chk("cop_rdata", e, cop_rdata);
  endtask
  task automatic hit(input logic [3:0] k, input logic [31:0] a, input logic [7:0] t, input logic e);
    m.issue(k, a, t);
    seen = watch_exc;
    @(negedge core_clk);
    chk("watch_exc", {31'h0, e}, {31'h0, seen | watch_exc});
  endtask
  task automatic t_regs;
    rd(5'h13, 3'h3, 32'h0);
    wr(5'h13, 3'h0, 32'hffff_fff8);
    rd(5'h13, 3'h0, 32'hc0ff_0ff8);
    wr(5'h12, 3'h0, 32'h0000_0ff8);
    rd(5'h12, 3'h0, 32'h0000_0ff8);
    wr(5'h11, 3'h0, 32'hffff_ffff);
    rd(5'h11, 3'h0, 32'h0);
    rd(5'h14, 3'h0, 32'h0);
    $display("regs test done");
  endtask
  task automatic t_fetch;
    wr(5'h12, 3'h1, 32'h0000_4004);
    wr(5'h13, 3'h1, 32'h4000_0000);
    hit(4'h8, 32'h0000_4000, 8'h77, 1'b1);
    hit(4'h4, 32'h0000_4000, 8'h77, 1'b0);
    rd(5'h13, 3'h1, 32'hc000_0004);
    wr(5'h13, 3'h1, 32'h4000_0004);
    rd(5'h13, 3'h1, 32'hc000_0000);
    $display("fetch test done");
  endtask
  task automatic t_load;
    wr(5'h12, 3'h2, 32'h0000_1002);
    wr(5'h13, 3'h2, 32'h005a_0008);
    hit(4'h4, 32'h0000_1008, 8'h5a, 1'b1);
    hit(4'h4, 32'h0000_1008, 8'h33, 1'b0);
    hit(4'h8, 32'h0000_1000, 8'h5a, 1'b0);
    hit(4'h4, 32'h0000_1010, 8'h5a, 1'b0);
    rd(5'h13, 3'h2, 32'h805a_000a);
    // clear and a fresh load hit in one cycle: the set must win
    fork
      wr(5'h13, 3'h2, 32'h005a_000a);
      m.issue(4'h4, 32'h0000_1008, 8'h5a);
    join
    rd(5'h13, 3'h2, 32'h805a_000a);
    wr(5'h13, 3'h2, 32'h005a_000a);
    rd(5'h13, 3'h2, 32'h805a_0008);
    $display("load test done");
  endtask
  task automatic t_defer;
    wr(5'h12, 3'h3, 32'h0000_2001);
    wr(5'h13, 3'h3, 32'h4000_0000);
    m.levels(1'b1, 1'b0);
    hit(4'h2, 32'h0000_2000, 8'h00, 1'b0);
    m.levels(1'b0, 1'b1);
    @(negedge core_clk);
    chk("watch_pending", 32'h1, {31'h0, watch_pending});
    m.levels(1'b0, 1'b0);
    @(negedge core_clk);
    chk("watch_exc", 32'h1, {31'h0, watch_exc});
    rd(5'h13, 3'h3, 32'h4000_0001);
    wr(5'h13, 3'h3, 32'h4000_0001);
    rd(5'h13, 3'h3, 32'h4000_0000);
    $display("defer test done");
  endtask
  task automatic t_ll;
    // park the bus on the capture register so the bound checker sees the capture
    rd(5'h11, 3'h0, 32'h0);
    hit(4'h1, 32'hffff_fff0, 8'h00, 1'b0);
    rd(5'h11, 3'h0, 32'h0fff_fff0);
    $display("reserved load test done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    {rst_n, cop_wr, cop_reg, cop_sel, cop_wdata} = '0;
    repeat (6) @(negedge core_clk);
    rst_n = 1;
    t_regs;
    t_fetch;
    t_load;
    t_defer;
    t_ll;
    report_and_stop;
  end
  initial begin
    #50us;
    miscompares++;
    report_and_stop;
  end
endmodule
